// ---- include/lmp_regs.vh ----
// Purpose: register map, fields and timing of the serial page-access unit
// Assumes: byte-wide registers reached over the two-wire serial port
// Notes:   definitions only
`ifndef LMP_REGS_VH
`define LMP_REGS_VH

`define LMP_OFS_IRQ_MASK      8'hf0
`define LMP_OFS_IRQ_FLAGS     8'hf1
`define LMP_OFS_PAGE_SEL      8'hfd
`define LMP_OFS_UNLOCK        8'hfe

`define LMP_DEV_ADDR_TOP      3'h5
`define LMP_UNLOCK_KEY        8'hc5
`define LMP_UNLOCK_RST        8'h00
`define LMP_MASK_RST          4'h0
`define LMP_FLAGS_RST         5'h00
`define LMP_PAGE_RST          2'h0
`define LMP_PAGE_MAX          8'h03

`define LMP_MASK_AUTO_CLR     3
`define LMP_MASK_BREATH       2
`define LMP_MASK_SHORT        1
`define LMP_MASK_OPEN         0

`define LMP_FLAG_BREATH_LO    2
`define LMP_FLAG_BREATH_HI    4
`define LMP_FLAG_SHORT        1
`define LMP_FLAG_OPEN         0

`define LMP_PG0_RD_FIRST      8'h18
`define LMP_PG0_RD_LAST       8'h45
`define LMP_PG3_RD_ADDR       8'h11
`define LMP_PAGE_LED          2'h0
`define LMP_PAGE_FUNC         2'h3

`define LMP_CLK_PERIOD_NS     10
`define LMP_AUTO_CLR_NS       8000000
`define LMP_AUTO_CLR_CYC      (`LMP_AUTO_CLR_NS / `LMP_CLK_PERIOD_NS)

`endif

// ---- rtl/lmp_i2c_page.v ----
// Purpose: serial slave port, page select with unlock key, interrupt mask
//          and flags for an led matrix driver
// Assumes: bus wires and straps are asynchronous pins; page contents live
//          outside and return read data combinationally from o_page/o_ptr
// Notes:   sda is open drain: o_sda_oe high pulls the wire low
//
// Behaviour
// - Answer to 7-bit address plus direction bit; 0 write, 1 read.
// - Top three address bits are fixed at 101.
// - Each strap gives two bits: gnd 00, scl 01, sda 10, supply 11.
// - Sample sda while scl high; sda idles high between transfers.
// - Sda falling with scl high is start; then compare address.
// - Sda rising with scl high is stop; transfer ends.
// - Pull sda low on ninth clock when address byte matched.
// - Register address byte follows, msb first, and is acknowledged.
// - Write data bytes msb first, each one acknowledged.
// - Pointer increments by one during each data acknowledge.
// - Only unlock key, flags, page0 18h-45h, 11h on page0 or page3 read back.
// - Read: write address, register, repeated start, read address.
// - Page select values 0..3 pick pages; others reserved.
// - Page writes land in selected page; page resets to zero.
// - Page select locked after reset; unlock key resets to 00h.
// - Key c5h allows one page select write, then key returns 00h.
// - Mask bit 3 auto-clears interrupt after output low over 8 ms.
// - Mask bit 2 enables the breathing loop done interrupt.
// - Mask bits 1, 0 enable short and open interrupts; reset 0.
// - Flags: breathing done bits 4..2, short bit 1, open bit 0.
`timescale 1ns/1ps
`default_nettype none
`include "lmp_regs.vh"
module lmp_i2c_page #(
    parameter integer P_AUTO_CLR_CYC = `LMP_AUTO_CLR_CYC,
    parameter integer P_AC_W         = 20
) (
    input  wire       i_core_clk,
    input  wire       i_rst,
    input  wire       i_scl,
    input  wire       i_sda,
    output reg        o_sda_out,
    output reg        o_sda_oe,
    input  wire       i_addr_strap_low,
    input  wire       i_addr_strap_high,
    input  wire [2:0] i_breath_done,
    input  wire       i_short_evt,
    input  wire       i_open_evt,
    input  wire [7:0] i_page_rd_data,
    output reg  [1:0] o_page,
    output reg  [7:0] o_ptr,
    output reg        o_wr_stb,
    output reg  [1:0] o_wr_page,
    output reg  [7:0] o_wr_addr,
    output reg  [7:0] o_wr_data,
    output reg        o_irq_out_n
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_REG  = 3'h2;
    localparam [2:0] S_WR   = 3'h3;
    localparam [2:0] S_RD   = 3'h4;
    localparam [2:0] S_WAIT = 3'h5;

    localparam [P_AC_W-1:0] AC_LIMIT = P_AUTO_CLR_CYC[P_AC_W-1:0];

    wire [3:0] sync_w;
    wire       scl_s;
    wire       sda_s;
    wire       strap_lo_s;
    wire       strap_hi_s;
    wire [1:0] addr_lo_bits;
    wire [1:0] addr_hi_bits;

    reg        scl_p_q;
    reg        sda_p_q;
    reg  [2:0] st_q;
    reg  [3:0] cnt_q;
    reg        ack_q;
    reg  [7:0] sh_q;
    reg  [7:0] tx_q;
    reg        rd_dir_q;
    reg  [7:0] key_q;
    reg  [3:0] mask_q;
    reg  [4:0] flags_q;
    reg        flags_rd_clr;
    reg  [P_AC_W-1:0] ac_cnt_q;

    lmp_sync #(
        .W (4)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    ({i_addr_strap_high, i_addr_strap_low, i_sda, i_scl}),
        .o_sync     (sync_w)
    );

    assign scl_s      = sync_w[0];
    assign sda_s      = sync_w[1];
    assign strap_lo_s = sync_w[2];
    assign strap_hi_s = sync_w[3];

    lmp_strap_dec u_strap_lo (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_strap    (strap_lo_s),
        .i_scl      (scl_s),
        .i_sda      (sda_s),
        .o_bits     (addr_lo_bits)
    );

    lmp_strap_dec u_strap_hi (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_strap    (strap_hi_s),
        .i_scl      (scl_s),
        .i_sda      (sda_s),
        .o_bits     (addr_hi_bits)
    );

    // bus events seen on the synchronised wires
    wire scl_rise  = scl_s & ~scl_p_q;
    wire scl_fall  = ~scl_s & scl_p_q;
    wire start_evt = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_evt  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    wire [6:0] own_addr = {`LMP_DEV_ADDR_TOP, addr_hi_bits, addr_lo_bits};
    wire       addr_hit = (sh_q[7:1] == own_addr);

    wire key_armed = (key_q == `LMP_UNLOCK_KEY);

    // readable locations; everything else returns zero
    wire pg0_rd = (o_page == `LMP_PAGE_LED) &&
                  (o_ptr >= `LMP_PG0_RD_FIRST) && (o_ptr <= `LMP_PG0_RD_LAST);
    wire pg3_rd = (o_ptr == `LMP_PG3_RD_ADDR) &&
                  ((o_page == `LMP_PAGE_LED) || (o_page == `LMP_PAGE_FUNC));
    reg  [7:0] rd_byte;
    always @* begin
        if (o_ptr == `LMP_OFS_UNLOCK)
            rd_byte = key_q;
        else if (o_ptr == `LMP_OFS_IRQ_FLAGS)
            rd_byte = {3'h0, flags_q};
        else if (pg0_rd || pg3_rd)
            rd_byte = i_page_rd_data;
        else
            rd_byte = 8'h00;
    end

    wire is_page_addr = (o_ptr != `LMP_OFS_IRQ_MASK) && (o_ptr != `LMP_OFS_IRQ_FLAGS) &&
                        (o_ptr != `LMP_OFS_PAGE_SEL) && (o_ptr != `LMP_OFS_UNLOCK);

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // serial engine and register writes
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            st_q         <= S_IDLE;
            cnt_q        <= 4'h0;
            ack_q        <= 1'b0;
            sh_q         <= 8'h00;
            tx_q         <= 8'h00;
            rd_dir_q     <= 1'b0;
            o_sda_out    <= 1'b0;
            o_sda_oe     <= 1'b0;
            o_ptr        <= 8'h00;
            o_page       <= `LMP_PAGE_RST;
            key_q        <= `LMP_UNLOCK_RST;
            mask_q       <= `LMP_MASK_RST;
            o_wr_stb     <= 1'b0;
            o_wr_page    <= 2'h0;
            o_wr_addr    <= 8'h00;
            o_wr_data    <= 8'h00;
            flags_rd_clr <= 1'b0;
        end else begin
            o_sda_out    <= 1'b0;
            o_wr_stb     <= 1'b0;
            flags_rd_clr <= 1'b0;
            if (start_evt) begin
                st_q     <= S_ADDR;
                cnt_q    <= 4'h0;
                ack_q    <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (stop_evt) begin
                st_q     <= S_IDLE;
                cnt_q    <= 4'h0;
                ack_q    <= 1'b0;
                o_sda_oe <= 1'b0;
            end else begin
                case (st_q)
                    S_ADDR, S_REG, S_WR: begin
                        if (scl_rise && (cnt_q < 4'h8)) begin
                            sh_q  <= {sh_q[6:0], sda_s};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && ack_q) begin
                            // ninth clock over: release sda, or drive bit 7 of a read byte; next byte
                            ack_q    <= 1'b0;
                            cnt_q    <= 4'h0;
                            o_sda_oe <= 1'b0;
                            if (st_q == S_ADDR) begin
                                if (rd_dir_q) begin
                                    st_q         <= S_RD;
                                    tx_q         <= rd_byte;
                                    o_sda_oe     <= ~rd_byte[7];
                                    flags_rd_clr <= (o_ptr == `LMP_OFS_IRQ_FLAGS);
                                end else begin
                                    st_q <= S_REG;
                                end
                            end else begin
                                st_q <= S_WR;
                            end
                        end else if (scl_fall && (cnt_q == 4'h8)) begin
                            case (st_q)
                                S_ADDR: begin
                                    if (addr_hit) begin
                                        ack_q    <= 1'b1;
                                        o_sda_oe <= 1'b1;
                                        rd_dir_q <= sh_q[0];
                                    end else begin
                                        st_q <= S_WAIT;
                                    end
                                end
                                S_REG: begin
                                    ack_q    <= 1'b1;
                                    o_sda_oe <= 1'b1;
                                    o_ptr    <= sh_q;
                                end
                                default: begin
                                    ack_q    <= 1'b1;
                                    o_sda_oe <= 1'b1;
                                    o_ptr    <= o_ptr + 8'h01;
                                    if (o_ptr == `LMP_OFS_UNLOCK) begin
                                        key_q <= sh_q;
                                    end else if (o_ptr == `LMP_OFS_PAGE_SEL) begin
                                        // reserved values still use up the key
                                        if (key_armed) begin
                                            key_q <= `LMP_UNLOCK_RST;
                                            if (sh_q <= `LMP_PAGE_MAX)
                                                o_page <= sh_q[1:0];
                                        end
                                        // locked: write dropped
                                    end else if (o_ptr == `LMP_OFS_IRQ_MASK) begin
                                        mask_q <= sh_q[3:0];
                                    end else if (is_page_addr) begin
                                        o_wr_stb  <= 1'b1;
                                        o_wr_page <= o_page;
                                        o_wr_addr <= o_ptr;
                                        o_wr_data <= sh_q;
                                    end
                                end
                            endcase
                        end
                    end
                    S_RD: begin
                        if (scl_rise && (cnt_q < 4'h8)) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_rise) begin
                            // master ack low: next byte; high ends read
                            if (!sda_s) begin
                                o_ptr <= o_ptr + 8'h01;
                                cnt_q <= 4'h0;
                            end else begin
                                st_q <= S_WAIT;
                            end
                        end else if (scl_fall && (cnt_q == 4'h8)) begin
                            o_sda_oe <= 1'b0;
                        end else if (scl_fall && (cnt_q == 4'h0)) begin
                            tx_q         <= rd_byte;
                            o_sda_oe     <= ~rd_byte[7];
                            flags_rd_clr <= (o_ptr == `LMP_OFS_IRQ_FLAGS);
                        end else if (scl_fall) begin
                            o_sda_oe <= ~tx_q[3'h7 - cnt_q[2:0]];
                        end
                    end
                    S_WAIT: begin
                        o_sda_oe <= 1'b0;
                    end
                    default: begin
                        o_sda_oe <= 1'b0;
                        cnt_q    <= 4'h0;
                    end
                endcase
            end
        end
    end

    // interrupt flags: sticky, set wins over any clear
    wire [4:0] evt = {i_breath_done, i_short_evt, i_open_evt};
    wire [4:0] en  = {{3{mask_q[`LMP_MASK_BREATH]}},
                      mask_q[`LMP_MASK_SHORT], mask_q[`LMP_MASK_OPEN]};
    wire       ac_fire = mask_q[`LMP_MASK_AUTO_CLR] && (ac_cnt_q >= AC_LIMIT);
    wire       flag_clr = flags_rd_clr | ac_fire;

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            flags_q     <= `LMP_FLAGS_RST;
            ac_cnt_q    <= {P_AC_W{1'b0}};
            o_irq_out_n <= 1'b1;
        end else begin
            flags_q     <= (flag_clr ? 5'h00 : flags_q) | evt;
            o_irq_out_n <= ~|(((flag_clr ? 5'h00 : flags_q) | evt) & en);
            // counter runs only while the output is held low
            if (!o_irq_out_n && mask_q[`LMP_MASK_AUTO_CLR] && !ac_fire)
                ac_cnt_q <= ac_cnt_q + {{(P_AC_W-1){1'b0}}, 1'b1};
            else
                ac_cnt_q <= {P_AC_W{1'b0}};
        end
    end
endmodule
`default_nettype wire

// ---- rtl/lmp_strap_dec.v ----
// Purpose: decode one address strap pin into two address bits
// Assumes: strap, scl and sda already synchronised to the core clock
// Notes:   the strap may be tied low, high, or to either bus wire
`timescale 1ns/1ps
`default_nettype none
`include "lmp_regs.vh"
module lmp_strap_dec (
    input  wire       i_core_clk,
    input  wire       i_rst,
    input  wire       i_strap,
    input  wire       i_scl,
    input  wire       i_sda,
    output wire [1:0] o_bits
);
    reg seen_hi_q;
    reg seen_lo_q;
    reg diff_scl_q;
    reg [1:0] settle_q;

    // a pin that never differed from scl since reset is tied to scl;
    // the start condition already separates scl from sda before any compare
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            seen_hi_q  <= 1'b0;
            seen_lo_q  <= 1'b0;
            diff_scl_q <= 1'b0;
            settle_q   <= 2'h0;
        end else if (!settle_q[1]) begin
            // synchroniser still shows its reset level for two edges
            settle_q <= settle_q + 2'h1;
        end else begin
            if (i_strap)
                seen_hi_q <= 1'b1;
            else
                seen_lo_q <= 1'b1;
            if (i_strap != i_scl)
                diff_scl_q <= 1'b1;
        end
    end

    assign o_bits = !seen_hi_q  ? 2'h0 :
                    !seen_lo_q  ? 2'h3 :
                    !diff_scl_q ? 2'h1 : 2'h2;
endmodule
`default_nettype wire

// ---- rtl/lmp_sync.v ----
// Purpose: two-stage synchroniser for asynchronous pin levels
// Assumes: inputs are slow levels relative to the core clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lmp_sync #(
    parameter W = 4
) (
    input  wire         i_core_clk,
    input  wire         i_rst,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // reset to high: an idle two-wire bus rests high
            always @(posedge i_core_clk) begin
                if (i_rst) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end else begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- verification/lmp_bus_master.sv ----
// Purpose: bus master model for the two-wire port
// Assumes: 125 ns bus clock, pull-up on the data wire
// Notes:   clock stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module lmp_bus_master (
    output logic      o_scl,
    output logic      o_sda_pull,
    input  wire logic i_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    // data moves 20 ns after scl falls so the synced copies keep their order
    task automatic bit_io(input logic b, output logic s);
        #20 o_sda_pull = ~b;
        #42.5 o_scl = 1'b1;
        #31.25 s = i_sda;
        #31.25 o_scl = 1'b0;
    endtask
    task automatic start();
        if (!o_scl) begin
            #50 o_sda_pull = 1'b0;
            #12.5 o_scl = 1'b1;
        end
        #31.25 o_sda_pull = 1'b1;
        #31.25 o_scl = 1'b0;
    endtask
    task automatic stop();
        #20 o_sda_pull = 1'b1;
        #42.5 o_scl = 1'b1;
        #31.25 o_sda_pull = 1'b0;
        #31.25;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

// ---- verification/lmp_i2c_page_monitor.sv ----
// Purpose: port-level assertions for the serial page-access unit
// Assumes: bus clock far slower than the core clock
// Notes:   bound to every instance of the unit
`timescale 1ns/1ps
`default_nettype none
module lmp_i2c_page_monitor #(
    parameter integer P_AUTO_CLR_CYC = 50,
    parameter integer P_AC_W         = 20
) (
    input wire logic       i_core_clk,
    input wire logic       i_rst,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda_out,
    input wire logic       o_sda_oe,
    input wire logic       i_addr_strap_low,
    input wire logic       i_addr_strap_high,
    input wire logic [2:0] i_breath_done,
    input wire logic       i_short_evt,
    input wire logic       i_open_evt,
    input wire logic [7:0] i_page_rd_data,
    input wire logic [1:0] o_page,
    input wire logic [7:0] o_ptr,
    input wire logic       o_wr_stb,
    input wire logic [1:0] o_wr_page,
    input wire logic [7:0] o_wr_addr,
    input wire logic [7:0] o_wr_data,
    input wire logic       o_irq_out_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire evt_any = (|i_breath_done) | i_short_evt | i_open_evt;

    a_drive_zero: assert property (o_sda_out == 1'b0)
        else $error("sda output value not zero");
    a_oe_scl_low: assert property (!$stable(o_sda_oe) |-> !i_scl)
        else $error("sda drive changed while scl high");
    a_start_quiet: assert property ((i_scl && $fell(i_sda)) |=> !o_sda_oe [*8])
        else $error("sda driven right after start");
    a_stop_idle: assert property ((i_scl && $rose(i_sda)) |=> (!o_sda_oe && !o_wr_stb) [*8])
        else $error("activity right after stop");
    a_stb_pulse: assert property (o_wr_stb |=> !o_wr_stb)
        else $error("write strobe longer than one cycle");
    a_stb_hold: assert property (o_wr_stb |=> $stable({o_wr_page, o_wr_addr, o_wr_data}) [*8])
        else $error("write fields moved after strobe");
    a_ptr_step: assert property (o_wr_stb |-> ##[0:8] (o_ptr == o_wr_addr + 8'h01))
        else $error("pointer did not step after write");
    a_stb_page: assert property (o_wr_stb |-> (o_wr_page == o_page))
        else $error("write landed outside selected page");
    a_page_lock: assert property (!$stable(o_page) |-> o_sda_oe)
        else $error("page changed outside a write acknowledge");
    a_irq_cause: assert property ($fell(o_irq_out_n) |-> ($past(evt_any) || o_sda_oe))
        else $error("interrupt fell without event or mask write");
    a_reset_idle: assert property (disable iff (1'b0) i_rst |=>
        (o_irq_out_n && !o_sda_oe && !o_wr_stb && o_page == 2'h0 && o_ptr == 8'h00))
        else $error("outputs not idle after reset");

    c_wr_stb: cover property (o_wr_stb);
    c_irq_low: cover property ($fell(o_irq_out_n));
    c_page_set: cover property (!$stable(o_page));
endmodule

bind lmp_i2c_page lmp_i2c_page_monitor #(
    .P_AUTO_CLR_CYC(P_AUTO_CLR_CYC), .P_AC_W(P_AC_W)) u_mon (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_addr_strap_low(i_addr_strap_low),
    .i_addr_strap_high(i_addr_strap_high), .i_breath_done(i_breath_done),
    .i_short_evt(i_short_evt), .i_open_evt(i_open_evt), .i_page_rd_data(i_page_rd_data),
    .o_page(o_page), .o_ptr(o_ptr), .o_wr_stb(o_wr_stb), .o_wr_page(o_wr_page),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_irq_out_n(o_irq_out_n));
`default_nettype wire

// ---- verification/lmp_i2c_page_tb.sv ----
// Purpose: self-checking bench for the serial page-access unit
// Assumes: master model on the bus, short auto-clear count
// Notes:   page write strobes are matched against a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "lmp_regs.vh"
module lmp_i2c_page_tb;
    localparam int AC = 50;
    logic        core_clk, rst, scl, pull, oe, stb, irq_n, sh, op, ack;
    logic [1:0]  lo_sel, hi_sel, page, wr_page, exp_page;
    logic [2:0]  brd;
    logic [6:0]  dev;
    logic [7:0]  ptr, wr_addr, wr_data;
    logic [7:0]  wbuf [0:3];
    logic [7:0]  rbuf [0:3];
    logic [7:0]  pv [0:4] = '{8'h01, 8'h00, 8'h02, 8'h07, 8'h03};
    logic [17:0] exp_q [$];
    int          n_fail, cmp_count, seed, t;
    wire logic       sda = ~(pull | oe);
    wire logic       strap_lo = lo_sel[1] ? (lo_sel[0] | sda) : (lo_sel[0] & scl);
    wire logic       strap_hi = hi_sel[1] ? (hi_sel[0] | sda) : (hi_sel[0] & scl);
    wire logic [7:0] rdd = {page, ptr[5:0]} ^ 8'ha5;

    lmp_i2c_page #(.P_AUTO_CLR_CYC(AC), .P_AC_W(20)) dut (
        .i_core_clk(core_clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(),
        .o_sda_oe(oe), .i_addr_strap_low(strap_lo), .i_addr_strap_high(strap_hi),
        .i_breath_done(brd), .i_short_evt(sh), .i_open_evt(op), .i_page_rd_data(rdd),
        .o_page(page), .o_ptr(ptr), .o_wr_stb(stb), .o_wr_page(wr_page),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_irq_out_n(irq_n));
    lmp_bus_master bfm (.o_scl(scl), .o_sda_pull(pull), .i_sda(sda));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] k);
        @(negedge core_clk);
        rst = 1'b1;
        lo_sel = k;
        hi_sel = 2'h3 - k;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic addr(input logic rd);
        bfm.start();
        bfm.wbyte({dev, rd}, ack);
        check(ack, 1'b1);
    endtask
    task automatic wr(input logic [7:0] ra, input int n);
        addr(1'b0);
        bfm.wbyte(ra, ack);
        check(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            if (ra < 8'hf0) exp_q.push_back({exp_page, ra + i[7:0], wbuf[i]});
            bfm.wbyte(wbuf[i], ack);
            check(ack, 1'b1);
        end
        bfm.stop();
    endtask
    task automatic wr1(input logic [7:0] ra, input logic [7:0] d);
        wbuf[0] = d;
        wr(ra, 1);
    endtask
    task automatic rd(input logic [7:0] ra, input int n);
        addr(1'b0);
        bfm.wbyte(ra, ack);
        check(ack, 1'b1);
        addr(1'b1);
        for (int i = 0; i < n; i++) bfm.rbyte(i == n - 1, rbuf[i]);
        bfm.stop();
    endtask
    task automatic pulse(input logic [2:0] b, input logic s, input logic o);
        @(negedge core_clk);
        brd = b;
        sh = s;
        op = o;
        @(negedge core_clk);
        brd = 3'h0;
        sh = 1'b0;
        op = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask

    always @(negedge core_clk) begin
        if (stb === 1'b1) begin
            if (exp_q.size() > 0) check({wr_page, wr_addr, wr_data}, exp_q.pop_front());
            else check(18'h0, 18'h1);
        end
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        final_report();
    end

    initial begin
        seed = 32'h863e;
        {sh, op, brd, lo_sel, hi_sel, exp_page} = '0;
        rst = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        // every strap code on both pins, then a bad top bit is refused
        for (int k = 0; k < 4; k++) begin
            do_reset(k[1:0]);
            dev = {3'h5, hi_sel, lo_sel};
            bfm.start();
            bfm.wbyte({dev ^ 7'h40, 1'b0}, ack);
            check(ack, 1'b0);
            bfm.stop();
            rd(`LMP_OFS_UNLOCK, 1);
            check(rbuf[0], 8'h00);
        end
        rd(`LMP_OFS_IRQ_FLAGS, 1);
        check(rbuf[0], 8'h00);
        wr1(`LMP_OFS_PAGE_SEL, 8'h02);
        check(page, 2'h0);
        for (int p = 0; p < 5; p++) begin
            wr1(`LMP_OFS_UNLOCK, `LMP_UNLOCK_KEY);
            rd(`LMP_OFS_UNLOCK, 1);
            check(rbuf[0], `LMP_UNLOCK_KEY);
            wr1(`LMP_OFS_PAGE_SEL, pv[p]);
            if (pv[p] <= `LMP_PAGE_MAX) exp_page = pv[p][1:0];
            check(page, exp_page);
            rd(`LMP_OFS_UNLOCK, 1);
            check(rbuf[0], 8'h00);
            wr1(`LMP_OFS_PAGE_SEL, 8'h01);
            check(page, exp_page);
            for (int i = 0; i < 4; i++) wbuf[i] = 8'($random(seed));
            wr(8'h3e, 4);
        end
        rd(`LMP_PG3_RD_ADDR, 1);
        check(rbuf[0], {2'h3, 6'h11} ^ 8'ha5);
        wr1(`LMP_OFS_UNLOCK, `LMP_UNLOCK_KEY);
        wr1(`LMP_OFS_PAGE_SEL, 8'h00);
        exp_page = 2'h0;
        rd(8'h17, 2);
        check(rbuf[0], 8'h00);
        check(rbuf[1], {2'h0, 6'h18} ^ 8'ha5);
        rd(8'h45, 2);
        check(rbuf[0], {2'h0, 6'h05} ^ 8'ha5);
        check(rbuf[1], 8'h00);
        wr1(`LMP_OFS_IRQ_MASK, 8'h07);
        pulse(3'h0, 1'b1, 1'b0);
        repeat (AC + 10) @(negedge core_clk);
        check(irq_n, 1'b0);
        rd(`LMP_OFS_IRQ_FLAGS, 1);
        check(rbuf[0], 8'h02);
        check(irq_n, 1'b1);
        wr1(`LMP_OFS_IRQ_MASK, 8'h02);
        pulse(3'h5, 1'b0, 1'b1);
        check(irq_n, 1'b1);
        rd(`LMP_OFS_IRQ_FLAGS, 1);
        check(rbuf[0], 8'h15);
        wr1(`LMP_OFS_IRQ_MASK, 8'h0c);
        pulse(3'h2, 1'b0, 1'b0);
        check(irq_n, 1'b0);
        t = 0;
        while (irq_n !== 1'b1 && t < AC + 20) begin
            @(negedge core_clk);
            t++;
        end
        check((t >= AC - 5) && (t <= AC + 2), 1'b1);
        rd(`LMP_OFS_IRQ_FLAGS, 1);
        check(rbuf[0], 8'h00);
        check(18'(exp_q.size()), 18'h0);
        final_report();
    end
endmodule
`default_nettype wire
